//--- verilog/scpc_socket.sv
// Local design decision: the address-and-strobe port.
module scpc_socket
    import scpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [scpc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [scpc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [scpc_pkg::DATA_W-1:0] reg_rdata,
    output logic mgmt_irq,
    input wire logic card_detect_one_n,
    input wire logic card_detect_two_n,
    input wire logic card_ready_or_irq_pin,
    output logic vcc_3v3_sel_n,
    output logic vcc_5v_sel_n,
    output logic vpp_vcc_select,
    output logic prog_voltage_select,
    output logic [scpc_pkg::IRQ_LINES-1:0] irq_line,
    output logic io_interface_mode,
    input wire logic core_ce1_n,
    input wire logic core_ce2_n,
    input wire logic core_iord_n,
    input wire logic core_iowr_n,
    input wire logic core_oe_n,
    input wire logic core_reg_n,
    input wire logic core_we_n,
    input wire logic [scpc_pkg::CARD_ADDR_W-1:0] core_addr,
    input wire logic [scpc_pkg::CARD_DATA_W-1:0] core_wdata,
    input wire logic core_data_drive,
    output logic [scpc_pkg::CARD_DATA_W-1:0] core_rdata,
    output logic card_ce1_n,
    output logic card_ce2_n,
    output logic card_iord_n,
    output logic card_iowr_n,
    output logic card_oe_n,
    output logic card_reg_n,
    output logic card_we_n,
    output logic [scpc_pkg::CARD_ADDR_W-1:0] card_addr,
    output logic card_ctl_oe,
    output logic card_reset,
    output logic card_reset_oe,
    input wire logic [scpc_pkg::CARD_DATA_W-1:0] card_data_in,
    output logic [scpc_pkg::CARD_DATA_W-1:0] card_data_out,
    output logic card_data_oe
);
    import scpc_pkg::*;

    logic [DATA_W-1:0] power_ctl;
    logic [DATA_W-1:0] int_gen_ctl;
    logic [DATA_W-1:0] ext_ctl;
    logic [DATA_W-1:0] misc_ctl;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clear;

    // Pin order in the synchroniser bank
    localparam int PIN_COUNT = 3;
    localparam int PIN_DET_ONE = 0;
    localparam int PIN_DET_TWO = 1;
    localparam int PIN_READY = 2;

    // Bit positions of the pin status register
    localparam int ST_DET_ONE = 0;
    localparam int ST_DET_TWO = 1;
    localparam int ST_POWERED = 2;
    localparam int ST_READY = 3;

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_level;
    logic det_one_n;
    logic det_two_n;
    logic ready_level;
    logic present;
    logic present_d;
    logic removed;
    logic inserted;

    logic powered;
    logic drive_en;
    logic card_irq;
    logic card_irq_d;
    logic reset_level;
    logic [3:0] irq_lvl;
    logic [IRQ_LINES-1:0] next_irq_line;

    logic wr_power;
    logic wr_intgen;
    logic wr_ext;
    logic wr_misc;
    logic wr_status;
    logic wr_mask;
    logic [DATA_W-1:0] next_rdata;

    // Detects and the ready pin idle high, so the stages reset high
    assign pin_raw[PIN_DET_ONE] = card_detect_one_n;
    assign pin_raw[PIN_DET_TWO] = card_detect_two_n;
    assign pin_raw[PIN_READY] = card_ready_or_irq_pin;

    // Three stages per pin; a level is taken only once stages two and three agree
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin_sync
        logic [SYNC_DEPTH-1:0] stage;
        logic level;

        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                stage <= '1;
                level <= 1'b1;
            end else begin
                stage <= {stage[SYNC_DEPTH-2:0], pin_raw[p]};
                if (stage[SYNC_DEPTH-2] == stage[SYNC_DEPTH-1]) begin
                    level <= stage[SYNC_DEPTH-1];
                end
            end
        end

        assign pin_level[p] = level;
    end

    assign det_one_n = pin_level[PIN_DET_ONE];
    assign det_two_n = pin_level[PIN_DET_TWO];
    assign ready_level = pin_level[PIN_READY];

    // Fully inserted only when both detects are low
    assign present = !det_one_n && !det_two_n;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            present_d <= 1'b0;
            card_irq_d <= 1'b0;
        end else begin
            present_d <= present;
            card_irq_d <= card_irq;
        end
    end

    assign removed = present_d && !present;
    assign inserted = !present_d && present;

    assign wr_power = reg_wr && (reg_addr == OFF_POWER);
    assign wr_intgen = reg_wr && (reg_addr == OFF_INTGEN);
    assign wr_ext = reg_wr && (reg_addr == OFF_EXT);
    assign wr_misc = reg_wr && (reg_addr == OFF_MISC);
    assign wr_status = reg_wr && (reg_addr == OFF_EVT_STATUS);
    assign wr_mask = reg_wr && (reg_addr == OFF_EVT_MASK);

    // Power control register; removal beats a same-cycle software write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            power_ctl <= POWER_RESET;
        end else begin
            if (wr_power) begin
                power_ctl <= reg_wdata;
                if (ext_ctl[EXT_VCC_LOCK]) begin
                    power_ctl[PWR_VCC] <= power_ctl[PWR_VCC];
                end
            end
            if (removed && !ext_ctl[EXT_NO_AUTO_OFF]) begin
                power_ctl[PWR_VCC] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_gen_ctl <= INTGEN_RESET;
        end else if (wr_intgen) begin
            int_gen_ctl <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ext_ctl <= REG_ZERO;
        end else if (wr_ext) begin
            ext_ctl <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            misc_ctl <= REG_ZERO;
        end else if (wr_misc) begin
            misc_ctl <= reg_wdata;
        end
    end

    // Supply and output enables
    assign powered = power_ctl[PWR_VCC]
        && (!power_ctl[PWR_AUTO] || present);
    // Vcc bit left out of the enable on purpose: the enable table rules
    assign drive_en = present && power_ctl[PWR_CARD_EN];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            vcc_3v3_sel_n <= 1'b1;
            vcc_5v_sel_n <= 1'b1;
            vpp_vcc_select <= 1'b0;
            prog_voltage_select <= 1'b0;
        end else begin
            vcc_3v3_sel_n <= !(powered && misc_ctl[MISC_VCC_3V3]);
            vcc_5v_sel_n <= !(powered && !misc_ctl[MISC_VCC_3V3]);
            vpp_vcc_select <= powered
                && (power_ctl[PWR_VPP_HI:PWR_VPP_LO] == VPP_VCC_CODE);
            prog_voltage_select <= powered
                && (power_ctl[PWR_VPP_HI:PWR_VPP_LO] == VPP_PROG_CODE);
        end
    end

    // Card reset level: zero asserts, polarity flips in ATA mode
    assign reset_level = !int_gen_ctl[IG_CARD_RESET] ^ misc_ctl[MISC_ATA];

    // Socket-facing outputs, registered so enables and data move together
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            card_ctl_oe <= 1'b0;
            card_reset_oe <= 1'b0;
            card_data_oe <= 1'b0;
            card_reset <= 1'b0;
        end else begin
            card_ctl_oe <= drive_en;
            card_reset_oe <= drive_en;
            card_data_oe <= drive_en && core_data_drive;
            card_reset <= reset_level;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            card_ce1_n <= 1'b1;
            card_ce2_n <= 1'b1;
            card_iord_n <= 1'b1;
            card_iowr_n <= 1'b1;
            card_oe_n <= 1'b1;
            card_reg_n <= 1'b1;
            card_we_n <= 1'b1;
            card_addr <= '0;
            card_data_out <= '0;
            core_rdata <= '0;
        end else begin
            card_ce1_n <= core_ce1_n;
            card_ce2_n <= core_ce2_n;
            card_iord_n <= core_iord_n || !int_gen_ctl[IG_IO_MODE];
            card_iowr_n <= core_iowr_n || !int_gen_ctl[IG_IO_MODE];
            card_oe_n <= core_oe_n;
            card_reg_n <= core_reg_n;
            card_we_n <= core_we_n;
            card_addr <= core_addr;
            card_data_out <= core_wdata;
            core_rdata <= card_data_in;
        end
    end

    // In memory mode the shared pin is ready, never an interrupt
    assign card_irq = int_gen_ctl[IG_IO_MODE] && !ready_level && drive_en;
    assign irq_lvl = int_gen_ctl[IG_LVL_HI:IG_LVL_LO];

    // Lines 14 and 15 drop the card interrupt when given their other use
    always_comb begin
        next_irq_line = '0;
        if (card_irq && LVL_VALID[irq_lvl]) begin
            next_irq_line[irq_lvl] = 1'b1;
        end
        if (irq_lvl == LVL_CLK_ALT && misc_ctl[MISC_LINE14_CLK]) begin
            next_irq_line = '0;
        end
        if (irq_lvl == LVL_RING_ALT && misc_ctl[MISC_LINE15_RING]) begin
            next_irq_line = '0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_line <= '0;
            io_interface_mode <= 1'b0;
        end else begin
            irq_line <= next_irq_line;
            io_interface_mode <= int_gen_ctl[IG_IO_MODE];
        end
    end

    // Events; a new event wins over a same-cycle clear
    assign evt_set[EVT_REMOVED] = removed;
    assign evt_set[EVT_INSERTED] = inserted;
    assign evt_set[EVT_CARD_IRQ] = card_irq && !card_irq_d;
    assign evt_clear = wr_status ? reg_wdata[EVT_W-1:0] : '0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evt_status <= '0;
        end else begin
            evt_status <= (evt_status & ~evt_clear) | evt_set;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evt_mask <= '0;
        end else if (wr_mask) begin
            evt_mask <= reg_wdata[EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mgmt_irq <= 1'b0;
        end else begin
            mgmt_irq <= |(evt_status & evt_mask)
                && !int_gen_ctl[IG_MGMT_OFF];
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = REG_ZERO;
        unique case (reg_addr)
            OFF_POWER: next_rdata = power_ctl;
            OFF_INTGEN: next_rdata = int_gen_ctl;
            OFF_EXT: next_rdata = ext_ctl;
            OFF_MISC: next_rdata = misc_ctl;
            OFF_EVT_STATUS: next_rdata[EVT_W-1:0] = evt_status;
            OFF_EVT_MASK: next_rdata[EVT_W-1:0] = evt_mask;
            OFF_PIN_STATUS: begin
                next_rdata[ST_DET_ONE] = det_one_n;
                next_rdata[ST_DET_TWO] = det_two_n;
                next_rdata[ST_POWERED] = powered;
                next_rdata[ST_READY] = ready_level;
            end
            default: next_rdata = REG_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= REG_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= REG_ZERO;
        end
    end
endmodule

//--- verilog/scpc_pkg.sv
package scpc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CARD_ADDR_W = 26;
    localparam int CARD_DATA_W = 16;
    localparam int IRQ_LINES = 16;
    localparam int SYNC_DEPTH = 3;

    localparam logic [ADDR_W-1:0] OFF_POWER = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_INTGEN = 8'h03;
    localparam logic [ADDR_W-1:0] OFF_EXT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MISC = 8'h05;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h06;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h07;
    localparam logic [ADDR_W-1:0] OFF_PIN_STATUS = 8'h08;

    localparam logic [DATA_W-1:0] POWER_RESET = 8'h00;
    localparam logic [DATA_W-1:0] INTGEN_RESET = 8'h00;
    localparam logic [DATA_W-1:0] REG_ZERO = 8'h00;

    // Power control fields
    localparam int PWR_CARD_EN = 7;
    localparam int PWR_AUTO = 5;
    localparam int PWR_VCC = 4;
    localparam int PWR_VPP_HI = 1;
    localparam int PWR_VPP_LO = 0;
    localparam logic [1:0] VPP_VCC_CODE = 2'h1;
    localparam logic [1:0] VPP_PROG_CODE = 2'h2;

    // Interrupt and general control fields
    localparam int IG_CARD_RESET = 6;
    localparam int IG_IO_MODE = 5;
    localparam int IG_MGMT_OFF = 4;
    localparam int IG_LVL_HI = 3;
    localparam int IG_LVL_LO = 0;
    localparam logic [3:0] LVL_CLK_ALT = 4'he;
    localparam logic [3:0] LVL_RING_ALT = 4'hf;
    // Codes that name a real line
    localparam logic [IRQ_LINES-1:0] LVL_VALID = 16'hdeb8;

    // Extension control fields
    localparam int EXT_VCC_LOCK = 0;
    localparam int EXT_NO_AUTO_OFF = 1;

    // Misc fields
    localparam int MISC_ATA = 0;
    localparam int MISC_VCC_3V3 = 1;
    localparam int MISC_LINE14_CLK = 2;
    localparam int MISC_LINE15_RING = 3;

    // Event bits
    localparam int EVT_REMOVED = 0;
    localparam int EVT_INSERTED = 1;
    localparam int EVT_CARD_IRQ = 2;
    localparam int EVT_W = 3;
endpackage

//--- test/scpc_socket_props.sv
module scpc_socket_props
    import scpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic card_detect_one_n,
    input wire logic card_detect_two_n,
    input wire logic card_ctl_oe,
    input wire logic card_data_oe,
    input wire logic card_reset_oe,
    input wire logic vcc_3v3_sel_n,
    input wire logic vcc_5v_sel_n,
    input wire logic vpp_vcc_select,
    input wire logic prog_voltage_select,
    input wire logic [scpc_pkg::IRQ_LINES-1:0] irq_line,
    input wire logic io_interface_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // Six cycles: three sync stages, the agree filter and the output flop
    absent_float_a: assert property (
        (card_detect_one_n | card_detect_two_n) [*6] |-> !card_ctl_oe)
        else $error("socket driven with card absent");
    data_gate_a: assert property (card_data_oe |-> card_ctl_oe)
        else $error("data bus driven while socket floats");
    reset_gate_a: assert property (card_reset_oe == card_ctl_oe)
        else $error("reset pin enable differs from socket enable");
    vpp_single_a: assert property (!(vpp_vcc_select && prog_voltage_select))
        else $error("both vpp switches on");
    supply_single_a: assert property (vcc_3v3_sel_n || vcc_5v_sel_n)
        else $error("both supply selects on");
    vpp_needs_vcc_a: assert property ((vpp_vcc_select || prog_voltage_select) |->
        !(vcc_3v3_sel_n && vcc_5v_sel_n)) else $error("vpp on without vcc");
    irq_single_a: assert property ($onehot0(irq_line))
        else $error("several irq lines");
    irq_reserved_a: assert property ((irq_line & 16'h2147) == 16'h0)
        else $error("reserved irq line driven");
    irq_io_a: assert property (
        |irq_line |-> io_interface_mode || $past(io_interface_mode))
        else $error("card irq routed in memory mode");
endmodule

//--- test/scpc_card.sv
module scpc_card
    import scpc_pkg::*;
(
    input wire logic mclk,
    input wire logic present,
    input wire logic irq_req,
    input wire logic card_ctl_oe,
    input wire logic card_oe_n,
    output logic card_detect_one_n,
    output logic card_detect_two_n,
    output logic card_ready_or_irq_pin,
    output logic [scpc_pkg::CARD_DATA_W-1:0] card_data_in = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-ups: an empty socket reads high
    assign card_detect_one_n = !present;
    assign card_detect_two_n = !present;
    assign card_ready_or_irq_pin = !(present && irq_req);
    // Released bus toggles so a stale value never passes
    always @(posedge mclk) begin
        if (present && card_ctl_oe && !card_oe_n) card_data_in <= 16'h5a3c;
        else card_data_in <= ~card_data_in;
    end
endmodule

//--- test/scpc_socket_tb.sv
module scpc_socket_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scpc_pkg::*;
    logic mclk, nrst, reg_wr, reg_rd, mgmt_irq, present, irq_req, drive;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, seed;
    logic det_one_n, det_two_n, ready_pin, v3_n, v5_n, vppv, vppp, iom;
    logic ctl_oe, rst_o, rst_oe, d_oe;
    logic ce1, ce2, iord, iowr, oe, rg, we, c_ce1, c_ce2, c_iord, c_iowr, c_oe, c_rg, c_we;
    logic [15:0] irq, wdata, rdata, din, dout, dexp;
    logic [25:0] addr, caddr, ea;
    int err_count, total_checks, i;
    scpc_socket uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mgmt_irq(mgmt_irq),
        .card_detect_one_n(det_one_n), .card_detect_two_n(det_two_n),
        .card_ready_or_irq_pin(ready_pin),
        .vcc_3v3_sel_n(v3_n), .vcc_5v_sel_n(v5_n), .vpp_vcc_select(vppv),
        .prog_voltage_select(vppp), .irq_line(irq), .io_interface_mode(iom),
        .core_ce1_n(ce1), .core_ce2_n(ce2), .core_iord_n(iord), .core_iowr_n(iowr),
        .core_oe_n(oe), .core_reg_n(rg), .core_we_n(we), .core_addr(addr),
        .core_wdata(wdata), .core_data_drive(drive), .core_rdata(rdata),
        .card_ce1_n(c_ce1), .card_ce2_n(c_ce2), .card_iord_n(c_iord), .card_iowr_n(c_iowr),
        .card_oe_n(c_oe), .card_reg_n(c_rg), .card_we_n(c_we), .card_addr(caddr),
        .card_ctl_oe(ctl_oe), .card_reset(rst_o), .card_reset_oe(rst_oe),
        .card_data_in(din), .card_data_out(dout), .card_data_oe(d_oe));
    scpc_card card (.mclk(mclk), .present(present), .irq_req(irq_req), .card_ctl_oe(ctl_oe),
        .card_oe_n(c_oe), .card_detect_one_n(det_one_n), .card_detect_two_n(det_two_n),
        .card_ready_or_irq_pin(ready_pin), .card_data_in(din));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [15:0] exp_irq(input logic [3:0] c);
        if (c inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf})
            return 16'h1 << c;
        return 16'h0;
    endfunction
    task automatic chk(input string n, input logic [25:0] e, input logic [25:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", 26'(e), 26'(reg_rdata));
    endtask
    task automatic sup(input logic [3:0] e);
        chk("supply_pins", 26'(e), 26'({v3_n, v5_n, vppv, vppp}));
    endtask
    task automatic card_in(input logic p);
        @(posedge mclk);
        present <= p;
        for (i = 0; i < 20 && ctl_oe !== p; i++) @(posedge mclk);
        repeat (4) @(posedge mclk);
        #1;
        chk("card_ctl_oe", 26'(p), 26'(ctl_oe));
        if (ctl_oe !== p) finish_test();
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        {nrst, reg_wr, reg_rd, present, irq_req, drive} = '0;
        {ce1, ce2, iord, iowr, oe, rg, we} = '1;
        {reg_addr, reg_wdata, addr, wdata} = '0;
        {err_count, total_checks} = '0;
        seed = 8'h50;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFF_POWER, POWER_RESET);
        rd(OFF_INTGEN, INTGEN_RESET);
        rd(8'h40, REG_ZERO);
        chk("card_ctl_oe", 26'(0), 26'(ctl_oe));
        sup(4'hc);
        wr(OFF_POWER, 8'h90);
        sup(4'h8);
        chk("card_ctl_oe", 26'(0), 26'(ctl_oe));
        wr(OFF_MISC, 8'h02);
        sup(4'h4);
        card_in(1'b1);
        chk("card_reset", 26'(1), 26'(rst_o));
        chk("card_iord_n", 26'(1), 26'(c_iord));
        $display("power and enable test done");
        repeat (20) begin
            @(posedge mclk);
            seed = lfsr(seed);
            ea = {seed, seed, seed, seed[1:0]};
            addr <= ea;
            wdata <= {seed, ~seed};
            {ce1, ce2, iord, iowr, oe, rg, we} <= seed[6:0];
            drive <= seed[7];
            #1;
            dexp = din;
            @(posedge mclk);
            #1;
            chk("card_addr", ea, caddr);
            chk("card_we_n", 26'(seed[0]), 26'(c_we));
            chk("card_data", 26'({seed, ~seed}), 26'(dout));
            chk("card_strobes", 26'({seed[6:5], 2'b11, seed[2:0]}),
                26'({c_ce1, c_ce2, c_iord, c_iowr, c_oe, c_rg, c_we}));
            chk("card_data_oe", 26'(seed[7]), 26'(d_oe));
            chk("core_rdata", 26'(dexp), 26'(rdata));
        end
        $display("socket link test done");
        for (int v = 0; v < 4; v++) begin
            wr(OFF_POWER, 8'h90 | 8'(v));
            sup({2'b01, v == 1, v == 2});
        end
        wr(OFF_INTGEN, 8'h40);
        chk("card_reset", 26'(0), 26'(rst_o));
        wr(OFF_MISC, 8'h03);
        chk("card_reset", 26'(1), 26'(rst_o));
        wr(OFF_MISC, 8'h02);
        @(posedge mclk);
        irq_req <= 1'b1;
        iord <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            wr(OFF_INTGEN, 8'h60 | 8'(c));
            chk("irq_line", 26'(exp_irq(4'(c))), 26'(irq));
        end
        chk("io_interface_mode", 26'(1), 26'(iom));
        chk("card_iord_n", 26'(0), 26'(c_iord));
        wr(OFF_MISC, 8'h0a);
        chk("irq_line", 26'(0), 26'(irq));
        wr(OFF_MISC, 8'h02);
        wr(OFF_INTGEN, 8'h4e);
        chk("irq_line", 26'(0), 26'({iom, irq}));
        chk("card_iord_n", 26'(1), 26'(c_iord));
        @(posedge mclk);
        irq_req <= 1'b0;
        $display("irq routing test done");
        wr(OFF_POWER, 8'h10);
        chk("socket_oe", 26'(0), 26'({ctl_oe, rst_oe}));
        wr(OFF_POWER, 8'h80);
        sup(4'hc);
        chk("card_ctl_oe", 26'(1), 26'(ctl_oe));
        wr(OFF_EXT, 8'h01);
        wr(OFF_POWER, 8'h90);
        rd(OFF_POWER, 8'h80);
        wr(OFF_EXT, 8'h00);
        wr(OFF_POWER, 8'h90);
        rd(OFF_POWER, 8'h90);
        wr(OFF_EVT_MASK, 8'h01);
        wr(OFF_EVT_STATUS, 8'h07);
        chk("mgmt_irq", 26'(0), 26'(mgmt_irq));
        card_in(1'b0);
        rd(OFF_POWER, 8'h80);
        rd(OFF_EVT_STATUS, 8'h01);
        chk("mgmt_irq", 26'(1), 26'(mgmt_irq));
        wr(OFF_INTGEN, 8'h10);
        chk("mgmt_irq", 26'(0), 26'(mgmt_irq));
        wr(OFF_INTGEN, 8'h00);
        chk("mgmt_irq", 26'(1), 26'(mgmt_irq));
        wr(OFF_EVT_STATUS, 8'h01);
        chk("mgmt_irq", 26'(0), 26'(mgmt_irq));
        $display("event test done");
        wr(OFF_POWER, 8'hb0);
        sup(4'hc);
        wr(OFF_EXT, 8'h02);
        card_in(1'b1);
        sup(4'h4);
        card_in(1'b0);
        rd(OFF_POWER, 8'hb0);
        sup(4'hc);
        $display("auto power test done");
        finish_test();
    end
endmodule
bind scpc_socket scpc_socket_props props (.mclk(mclk), .nrst(nrst),
    .card_detect_one_n(card_detect_one_n), .card_detect_two_n(card_detect_two_n),
    .card_ctl_oe(card_ctl_oe), .card_data_oe(card_data_oe), .card_reset_oe(card_reset_oe),
    .vcc_3v3_sel_n(vcc_3v3_sel_n), .vcc_5v_sel_n(vcc_5v_sel_n),
    .vpp_vcc_select(vpp_vcc_select), .prog_voltage_select(prog_voltage_select),
    .irq_line(irq_line), .io_interface_mode(io_interface_mode));
